// [sdra_ctrl.v]
// Summary of operation
// - Without display grant, address bus carries A1-A8 on row, A9-A16 on column.
// - CPU write to low RAM: low lane enables odd byte, high lane even byte.
// - CPU read: low lane passes word bits 7:0, high lane bits 15:8.
// - Row strobe with row half, one memory cycle later column half and strobe.
// - Display row address from scan row and code 3:0, column from code 10:4.
// - Display accesses only read; grant disables CPU read buffers, word goes to video.
// - Every row refreshed within 2 ms, refresh counter on the address bus.
// - Refresh row counter advances with second phase low; column strobe suppressed.
// - Refresh starts only with no grant and display interval inactive.
// - CPU request sets on sync clock edge with ALE, memory select and region low.
// - CPU request clears when first phase high and display grant inactive; code also needs refresh inactive.
// - First phase sets on clock A when request or grant present, phases one, three idle.
// - Row/column select sets on clock B after first phase.
// - Pending CPU request blocks a new display grant.
// - Second phase follows first on clock A; column strobe on second phase without refresh.
// - Third phase follows second, holds three cycles, clears after second drops.
// - Select held until first phase clears; write strobe on select, write, third phase.
// - CPU data latch enable on select, third phase, region selected, no grant.
// - Display request on dot counter carry without grant; carry at fifteen or ten.
// - Grant sets on clock B with request, no CPU request, phases one, three idle.
// - Display row address enable needs select, grant and blank; latch from select, grant.
// - Latch pulse captures word to video; shifter load on carry at clock A.
//
// Added by the designer: the register addresses and the strobed register port.
`include "sdra_regs.vh"

module sdra_ctrl #(
  parameter REFRESH_INTERVAL = `SDRA_ROW_INTERVAL_CYC
) (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWriteData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regReadData,
  input  wire        memoryClockA,
  input  wire        memoryClockB,
  input  wire        cpuSyncClock,
  input  wire        addrLatchEnable,
  input  wire        memIoSelect,
  input  wire        lowRamRegionSelectN,
  input  wire        screenRegionSelectN,
  input  wire        transferDirection,
  input  wire [16:1] cpuAddr,
  input  wire        byteLaneSelect,
  input  wire        ioDataLatchEnable,
  input  wire        displayActiveInterval,
  input  wire        displayBlank,
  input  wire [3:0]  scanRowCount,
  input  wire [10:0] characterCodeBus,
  input  wire [15:0] dramDataWord,
  output reg  [7:0]  dramAddressBus,
  output reg         rowStrobeN,
  output reg         colStrobeN,
  output reg         ramWriteStrobeN,
  output reg         writeOddN,
  output reg         writeEvenN,
  output reg         readBufferEvenN,
  output reg         readBufferOddN,
  output reg  [7:0]  cpuByteBus,
  output reg         cpuDataLatchEnableN,
  output reg         cpuByteLatch,
  output reg         displayAccessGrant,
  output reg         rowColSelect,
  output reg         displayRowAddrEnableN,
  output reg         displayColAddrEnableN,
  output reg         displayDataLatch,
  output reg  [15:0] videoWord,
  output reg         shifterLoad
);

  // Cycle counter states, one-hot.
  localparam [3:0] ST_IDLE   = 4'h1;
  localparam [3:0] ST_FIRST  = 4'h2;
  localparam [3:0] ST_SECOND = 4'h4;
  localparam [3:0] ST_THIRD  = 4'h8;

  reg  [1:0] ctrl;
  reg        clkAPrev;
  reg        clkBPrev;
  reg        syncPrev;
  reg        cyclePhaseFirst;
  reg        cyclePhaseSecond;
  reg        cyclePhaseThird;
  reg  [1:0] thirdCount;
  reg  [3:0] cycleState;
  reg        cpuRequestFlag;
  reg        displayRequest;
  reg        refreshActive;
  reg  [3:0] dotCount;

  wire       aEdge;
  wire       bEdge;
  wire       syncEdge;
  wire       high_resolution_mode;
  wire       dotCarry;
  wire       regionSel;
  wire       refreshDue;
  wire [7:0] refreshRow;
  wire       refreshStart;
  wire       refreshAdvance;
  wire       cpuStart;
  wire       dataLatchNow;

  reg  [7:0] next_addr;
  reg  [7:0] next_byte;

  // Decoded single-bit register match, used for both reads and writes.
  function match;
    input [7:0] a;
    input [7:0] want;
    begin
      match = (a == want);
    end
  endfunction

  assign aEdge     = memoryClockA & ~clkAPrev;
  assign bEdge     = memoryClockB & ~clkBPrev;
  assign syncEdge  = cpuSyncClock & ~syncPrev;
  assign high_resolution_mode     = ctrl[`SDRA_CTRL_HIGH_RESOLUTION_MODE_BIT];
  assign regionSel = ~lowRamRegionSelectN | ~screenRegionSelectN;

  assign dotCarry = (dotCount == (high_resolution_mode ? `SDRA_DOT_TOP_HIGH_RESOLUTION_MODE : `SDRA_DOT_TOP_STD));

  // CPU cycles take precedence; refresh only fills a quiet bus.
  assign refreshStart = refreshDue & ~displayAccessGrant & ~displayActiveInterval
                        & ~cpuRequestFlag & ~displayRequest & ~refreshActive
                        & ~cyclePhaseFirst & ~cyclePhaseThird & aEdge;
  assign cpuStart = (cpuRequestFlag | displayAccessGrant) & ~cyclePhaseFirst
                    & ~cyclePhaseThird & aEdge;
  assign refreshAdvance = refreshActive & ~cyclePhaseSecond & aEdge
                          & cyclePhaseFirst & ~cyclePhaseThird;
  assign dataLatchNow = rowColSelect & displayAccessGrant;

  sdra_refresh #(
    .INTERVAL (REFRESH_INTERVAL),
    .ROW_W    (8)
  ) uRefresh (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .enable  (ctrl[`SDRA_CTRL_REFEN_BIT]),
    .started (refreshStart),
    .advance (refreshAdvance),
    .due     (refreshDue),
    .row     (refreshRow)
  );

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clkAPrev <= 1'b0;
      clkBPrev <= 1'b1;
      syncPrev <= 1'b1;
    end else begin
      clkAPrev <= memoryClockA;
      clkBPrev <= memoryClockB;
      syncPrev <= cpuSyncClock;
    end
  end

  // Software port: control writes, status reads, unmapped reads return zero.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl        <= `SDRA_CTRL_RESET;
      regReadData <= 32'h0;
    end else begin
      if (regWrite && match(regAddr, `SDRA_ADDR_CTRL)) begin
        ctrl <= regWriteData[1:0];
      end
      if (regRead && match(regAddr, `SDRA_ADDR_CTRL)) begin
        regReadData <= {30'h0, ctrl};
      end else if (regRead && match(regAddr, `SDRA_ADDR_STATUS)) begin
        regReadData <= {16'h0, refreshRow, refreshActive, displayRequest,
                        cpuRequestFlag, displayAccessGrant, rowColSelect,
                        cyclePhaseThird, cyclePhaseSecond, cyclePhaseFirst};
      end else begin
        regReadData <= 32'h0;
      end
    end
  end

  // Processor request flag; a set in the same cycle as a clear wins.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cpuRequestFlag <= 1'b0;
    end else if (syncEdge && !addrLatchEnable && !memIoSelect && regionSel) begin
      cpuRequestFlag <= 1'b1;
    end else if (cyclePhaseFirst && !displayAccessGrant && !refreshActive) begin
      cpuRequestFlag <= 1'b0;
    end
  end

  // Dot counter, advanced on memory clock A; shifter load on its carry.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dotCount    <= 4'h0;
      shifterLoad <= 1'b0;
    end else begin
      shifterLoad <= aEdge & dotCarry;
      if (aEdge) begin
        if (dotCarry) begin
          dotCount <= high_resolution_mode ? `SDRA_DOT_BASE_HIGH_RESOLUTION_MODE : `SDRA_DOT_BASE_STD;
        end else begin
          dotCount <= dotCount + 4'h1;
        end
      end
    end
  end

  // Display request on the dot counter carry; grant set on memory clock B, cleared on memory clock A.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      displayRequest     <= 1'b0;
      displayAccessGrant <= 1'b0;
    end else begin
      if (dotCarry && !displayAccessGrant) begin
        displayRequest <= 1'b1;
      end else if (displayAccessGrant) begin
        displayRequest <= 1'b0;
      end
      if (bEdge && displayRequest && !displayAccessGrant && !cpuRequestFlag
          && !cyclePhaseFirst && !cyclePhaseThird && !refreshActive) begin
        displayAccessGrant <= 1'b1;
      end else if (aEdge && cyclePhaseThird && thirdCount == `SDRA_THIRD_LEN
                   && !cyclePhaseSecond) begin
        // The grant ends with the memory cycle it started, freeing the bus for the processor.
        displayAccessGrant <= 1'b0;
      end
    end
  end

  // Memory cycle counter on memory clock A.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cyclePhaseFirst  <= 1'b0;
      cyclePhaseSecond <= 1'b0;
      cyclePhaseThird  <= 1'b0;
      thirdCount       <= 2'h0;
      cycleState       <= ST_IDLE;
      refreshActive    <= 1'b0;
    end else if (aEdge) begin
      if (refreshStart) begin
        refreshActive <= 1'b1;
      end else if (cyclePhaseThird && thirdCount == `SDRA_THIRD_LEN
                   && !cyclePhaseSecond) begin
        refreshActive <= 1'b0;
      end
      if (cpuStart || refreshStart) begin
        cyclePhaseFirst <= 1'b1;
      end else if (cyclePhaseThird) begin
        cyclePhaseFirst <= 1'b0;
      end
      cyclePhaseSecond <= cyclePhaseFirst & ~cyclePhaseThird;
      if (cyclePhaseSecond && !cyclePhaseThird) begin
        cyclePhaseThird <= 1'b1;
        thirdCount      <= 2'h1;
      end else if (cyclePhaseThird && thirdCount != `SDRA_THIRD_LEN) begin
        thirdCount <= thirdCount + 2'h1;
      end else if (cyclePhaseThird && !cyclePhaseSecond) begin
        cyclePhaseThird <= 1'b0;
        thirdCount      <= 2'h0;
      end
      case (cycleState)
        ST_IDLE: begin
          if (cpuStart || refreshStart) begin
            cycleState <= ST_FIRST;
          end
        end
        ST_FIRST: begin
          cycleState <= ST_SECOND;
        end
        ST_SECOND: begin
          cycleState <= ST_THIRD;
        end
        ST_THIRD: begin
          if (cyclePhaseThird && thirdCount == `SDRA_THIRD_LEN && !cyclePhaseSecond) begin
            cycleState <= ST_IDLE;
          end
        end
        default: begin
          cycleState <= ST_IDLE;
        end
      endcase
    end
  end

  // Row/column select on memory clock B: follows the first phase.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rowColSelect <= 1'b0;
    end else if (bEdge) begin
      rowColSelect <= cyclePhaseFirst;
    end
  end

  // Address multiplexer and read byte steering.
  always @* begin
    next_addr = 8'h0;
    if (refreshActive) begin
      next_addr = refreshRow;
    end else if (displayAccessGrant) begin
      if (rowColSelect) begin
        next_addr = {1'b0, characterCodeBus[10:4]};
      end else begin
        next_addr = {scanRowCount, characterCodeBus[3:0]};
      end
    end else if (rowColSelect) begin
      next_addr = cpuAddr[16:9];
    end else begin
      next_addr = cpuAddr[8:1];
    end
    next_byte = byteLaneSelect ? dramDataWord[15:8] : dramDataWord[7:0];
  end

  // Strobes and enables are registered so every output leaves a flip-flop.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dramAddressBus        <= 8'h0;
      rowStrobeN            <= 1'b1;
      colStrobeN            <= 1'b1;
      ramWriteStrobeN       <= 1'b1;
      writeOddN             <= 1'b1;
      writeEvenN            <= 1'b1;
      readBufferEvenN       <= 1'b1;
      readBufferOddN        <= 1'b1;
      cpuByteBus            <= 8'h0;
      cpuDataLatchEnableN   <= 1'b1;
      cpuByteLatch          <= 1'b0;
      displayRowAddrEnableN <= 1'b1;
      displayColAddrEnableN <= 1'b1;
      displayDataLatch      <= 1'b0;
      videoWord             <= 16'h0;
    end else begin
      dramAddressBus <= next_addr;
      rowStrobeN     <= ~cyclePhaseFirst;
      colStrobeN     <= ~(cyclePhaseSecond & ~refreshActive);
      ramWriteStrobeN <= ~(rowColSelect & transferDirection & cyclePhaseThird
                           & ~displayAccessGrant & ~refreshActive);
      writeOddN  <= ~(rowColSelect & transferDirection & cyclePhaseThird
                      & ~lowRamRegionSelectN & ~displayAccessGrant
                      & ~refreshActive & ~byteLaneSelect);
      writeEvenN <= ~(rowColSelect & transferDirection & cyclePhaseThird
                      & ~lowRamRegionSelectN & ~displayAccessGrant
                      & ~refreshActive & byteLaneSelect);
      readBufferEvenN <= ~(~displayAccessGrant & ~transferDirection
                           & ~byteLaneSelect & regionSel);
      readBufferOddN  <= ~(~displayAccessGrant & ~transferDirection
                           & byteLaneSelect & regionSel);
      cpuByteBus <= next_byte;
      cpuDataLatchEnableN <= ~(rowColSelect & cyclePhaseThird & regionSel
                               & ~displayAccessGrant & ~refreshActive);
      cpuByteLatch <= ((rowColSelect & cyclePhaseThird & regionSel
                        & ~displayAccessGrant & ~refreshActive)
                       | ioDataLatchEnable) & addrLatchEnable;
      displayRowAddrEnableN <= ~(rowColSelect & displayAccessGrant & displayBlank);
      displayColAddrEnableN <= ~(rowColSelect & displayAccessGrant & ~displayBlank);
      displayDataLatch <= dataLatchNow;
      // Take the word in the last cycle of the column strobe, while the memory still drives it.
      if (dataLatchNow && !colStrobeN && !cyclePhaseSecond) begin
        videoWord <= dramDataWord;
      end
    end
  end

endmodule

// [sdra_ctrl_chk.sv]
module sdra_ctrl_chk (
  input logic ref_clk,
  input logic nrst,
  input logic rowStrobeN,
  input logic colStrobeN,
  input logic ramWriteStrobeN,
  input logic writeOddN,
  input logic writeEvenN,
  input logic readBufferEvenN,
  input logic readBufferOddN,
  input logic cpuDataLatchEnableN,
  input logic displayAccessGrant,
  input logic rowColSelect,
  input logic shifterLoad,
  input logic displayBlank,
  input logic displayRowAddrEnableN,
  input logic displayDataLatch
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_reset_idle: assert property ($rose(nrst) |->
    rowStrobeN && colStrobeN && ramWriteStrobeN && !displayAccessGrant)
    else $error("strobe or grant active after reset");
  a_row_bound: assert property ($fell(rowStrobeN) |-> ##[4:200] $rose(rowStrobeN))
    else $error("row strobe cycle out of bounds");
  a_col_in_row: assert property ($fell(colStrobeN) |-> !rowStrobeN && rowColSelect)
    else $error("column strobe without row strobe and column half");
  a_write_select: assert property (!ramWriteStrobeN |->
    $past(rowColSelect) && !$past(displayAccessGrant))
    else $error("write strobe without select or during grant");
  a_write_lanes: assert property ((!writeOddN || !writeEvenN) |->
    !ramWriteStrobeN && (writeOddN || writeEvenN))
    else $error("byte write enables inconsistent");
  a_grant_buffers: assert property (displayAccessGrant && $past(displayAccessGrant) |->
    readBufferEvenN && readBufferOddN)
    else $error("read buffer enabled during display grant");
  a_latch_no_grant: assert property (!cpuDataLatchEnableN |->
    $past(rowColSelect) && !$past(displayAccessGrant))
    else $error("processor latch enable out of place");
  a_row_addr_en: assert property (!displayRowAddrEnableN |->
    $past(rowColSelect) && $past(displayAccessGrant) && $past(displayBlank))
    else $error("display row address enable out of place");
  a_video_latch: assert property (displayDataLatch |->
    $past(rowColSelect) && $past(displayAccessGrant))
    else $error("display data latch out of place");
  a_load_pulse: assert property (shifterLoad |=> !shifterLoad)
    else $error("shifter load longer than one cycle");
  a_grant_starts: assert property ($rose(displayAccessGrant) |-> ##[1:40] !rowStrobeN)
    else $error("grant did not start a memory cycle");
endmodule

bind sdra_ctrl sdra_ctrl_chk i_sdra_ctrl_chk (.*);

// [sdra_far_model.sv]
module sdra_far_model (
  input  logic        ref_clk,
  input  logic        nrst,
  input  logic        rowStrobeN,
  input  logic        colStrobeN,
  input  logic [7:0]  dramAddressBus,
  output logic        memoryClockA,
  output logic        memoryClockB,
  output logic        cpuSyncClock,
  output logic [15:0] dramDataWord,
  output logic [15:0] modelWord
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] tick;
  logic [3:0] sync;
  logic [7:0] row;
  logic [7:0] col;
  logic [7:0] junk;
  logic       prevRas;
  logic       prevCas;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick <= 4'h0;
      sync <= 4'h0;
      junk <= 8'h5A;
      prevRas <= 1'h1;
      prevCas <= 1'h1;
    end else begin
      tick <= tick + 4'h1;
      sync <= (sync == 4'hB) ? 4'h0 : sync + 4'h1;
      junk <= junk + 8'h3B;
      prevRas <= rowStrobeN;
      prevCas <= colStrobeN;
      if (prevRas && !rowStrobeN) row <= dramAddressBus;
      if (prevCas && !colStrobeN) col <= dramAddressBus;
      if (!colStrobeN && !prevCas) modelWord <= {col, row};
    end
  end

  // Clock B rises half a clock A period after clock A, as two memory clock phases.
  assign memoryClockA = tick[2];
  assign memoryClockB = ~tick[2];
  assign cpuSyncClock = (sync < 4'h6);
  // Outside a column access the bus moves every cycle, so a stale word never looks valid.
  assign dramDataWord = (!colStrobeN && !prevCas) ? {col, row} : {junk, ~junk};
endmodule

// [sdra_refresh.v]
`include "sdra_regs.vh"

module sdra_refresh #(
  parameter INTERVAL = `SDRA_ROW_INTERVAL_CYC,
  parameter ROW_W    = 8
) (
  input  wire             ref_clk,
  input  wire             nrst,
  input  wire             enable,
  input  wire             started,
  input  wire             advance,
  output reg              due,
  output reg  [ROW_W-1:0] row
);

  reg [31:0] timer;

  // Due is raised once per row interval; a new tick beats a start in the same cycle.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timer <= 32'h0;
      due   <= 1'b0;
      row   <= {ROW_W{1'b0}};
    end else begin
      if (timer >= INTERVAL - 1) begin
        timer <= 32'h0;
      end else begin
        timer <= timer + 32'h1;
      end
      if (enable && timer >= INTERVAL - 1) begin
        due <= 1'b1;
      end else if (started) begin
        due <= 1'b0;
      end
      if (advance) begin
        row <= row + {{(ROW_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// [sdra_regs.vh]
`ifndef SDRA_REGS_VH
`define SDRA_REGS_VH

// Register byte addresses on the plain software port.
`define SDRA_ADDR_CTRL        8'h00
`define SDRA_ADDR_STATUS      8'h04

// Control register fields and reset value.
`define SDRA_CTRL_HIGH_RESOLUTION_MODE_BIT   0
`define SDRA_CTRL_REFEN_BIT   1
`define SDRA_CTRL_RESET       2'h2

// Dot counter carry points: high resolution wraps 0..15, standard 1..10.
`define SDRA_DOT_TOP_HIGH_RESOLUTION_MODE    4'hF
`define SDRA_DOT_TOP_STD      4'hA
`define SDRA_DOT_BASE_HIGH_RESOLUTION_MODE   4'h0
`define SDRA_DOT_BASE_STD     4'h1

// Third phase length in memory clock A cycles.
`define SDRA_THIRD_LEN        2'h3

// Refresh timing: every row within the window, clock period in ns.
`define SDRA_REFRESH_WINDOW_NS 2000000
`define SDRA_CLK_PERIOD_NS     5
`define SDRA_ROWS              256
`define SDRA_ROW_INTERVAL_CYC  (`SDRA_REFRESH_WINDOW_NS / `SDRA_CLK_PERIOD_NS / `SDRA_ROWS)

`endif

// [sdra_tb.sv]
`include "sdra_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [16:1] a; logic l; logic w; logic low;} sdra_note_t;
  localparam int APER = 8;
  logic        ref_clk = 0, nrst = 0, regWrite = 0, regRead = 0, rdPend = 0;
  logic [7:0]  regAddr = 8'h00, lastRef = 8'h00;
  logic [31:0] regWriteData = 32'h0;
  logic        addrLatchEnable = 1, memIoSelect = 0, lowRamRegionSelectN = 1;
  logic        screenRegionSelectN = 1, transferDirection = 0, byteLaneSelect = 0;
  logic        ioDataLatchEnable = 0, displayActiveInterval = 1, displayBlank = 1;
  logic [16:1] cpuAddr = 16'h0;
  logic [3:0]  scanRowCount = 4'h5;
  logic [10:0] characterCodeBus = 11'h2C7;
  wire  [31:0] regReadData;
  wire  [15:0] dramDataWord, videoWord, modelWord;
  wire  [7:0]  dramAddressBus, cpuByteBus;
  wire         memoryClockA, memoryClockB, cpuSyncClock, rowStrobeN, colStrobeN;
  wire         ramWriteStrobeN, writeOddN, writeEvenN, readBufferEvenN, readBufferOddN;
  wire         cpuDataLatchEnableN, cpuByteLatch, displayAccessGrant, rowColSelect;
  wire         displayRowAddrEnableN, displayColAddrEnableN, displayDataLatch, shifterLoad;
  int          fails = 0, check_count = 0, cyc = 0, seed = 62740, refCount = 0;
  int          lastLoad = 0, spanExp = 0, curSpan = 0;
  logic [31:0] regQ[$];
  sdra_note_t  cpuQ[$];

  sdra_ctrl #(.REFRESH_INTERVAL(20)) i_sdra_ctrl (.*);
  sdra_far_model i_sdra_far_model (.*);
  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic reg_acc(input logic rd, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    if (rd) regQ.push_back(d);
    regAddr <= a;
    regWriteData <= d;
    regRead <= rd;
    regWrite <= !rd;
    @(posedge ref_clk);
    regRead <= 0;
    regWrite <= 0;
  endtask

  // Address latch enable goes high once the cycle starts, so one request makes one cycle.
  task automatic cpu_acc();
    sdra_note_t n;
    int k;
    n.a = $random(seed);
    n.l = $random(seed);
    n.w = $random(seed);
    n.low = $random(seed);
    cpuQ.push_back(n);
    @(posedge ref_clk);
    cpuAddr <= n.a;
    displayBlank <= $random(seed);
    byteLaneSelect <= n.l;
    transferDirection <= n.w;
    lowRamRegionSelectN <= !n.low;
    screenRegionSelectN <= n.low;
    addrLatchEnable <= 0;
    for (k = 0; k < 2000 && !(rowStrobeN === 1'h0 && displayAccessGrant === 1'h0); k++)
      @(posedge ref_clk);
    addrLatchEnable <= 1;
    wait (rowStrobeN === 1'h1);
    repeat (40) @(posedge ref_clk);
    lowRamRegionSelectN <= 1;
    screenRegionSelectN <= 1;
  endtask

  always begin
    logic [7:0] rowAt, colAt;
    logic g, act, cas, wo, we, lt, gc, bl;
    sdra_note_t n;
    @(negedge rowStrobeN);
    #1;
    rowAt = dramAddressBus;
    g = displayAccessGrant;
    act = displayActiveInterval;
    {cas, wo, we, lt, gc, bl} = 6'h00;
    colAt = 8'h00;
    while (rowStrobeN === 1'h0) begin
      @(posedge ref_clk);
      #1;
      cas |= !colStrobeN;
      wo |= !writeOddN;
      we |= !writeEvenN;
      lt |= !cpuDataLatchEnableN;
      bl |= cpuByteLatch;
      if (!colStrobeN && !gc) colAt = dramAddressBus;
      gc |= !colStrobeN;
    end
    if (g) begin
      chk("display row", rowAt, {scanRowCount, characterCodeBus[3:0]});
      chk("display column", colAt, {1'b0, characterCodeBus[10:4]});
      repeat (6) @(posedge ref_clk);
      #1;
      chk("video word", videoWord, modelWord);
      chk("display write", {wo, we}, 2'h0);
    end else if (!cas) begin
      chk("refresh in display", act, 1'h0);
      if (refCount > 0) chk("refresh row", rowAt, lastRef + 8'h01);
      lastRef = rowAt;
      refCount++;
    end else if (cpuQ.size() > 0) begin
      n = cpuQ.pop_front();
      chk("row address", rowAt, n.a[8:1]);
      chk("column address", colAt, n.a[16:9]);
      chk("write lanes", {wo, we}, (n.w && n.low) ? (n.l ? 2'h1 : 2'h2) : 2'h0);
      chk("data latch", lt, 1'h1);
      chk("byte latch", bl, 1'h1);
      if (!n.w) chk("read byte", cpuByteBus, n.l ? n.a[16:9] : n.a[8:1]);
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (rdPend) chk("register read", regReadData, regQ.pop_front());
    rdPend <= regRead;
    if (spanExp != curSpan) begin
      curSpan = spanExp;
      lastLoad = 0;
    end
    if (shifterLoad === 1'h1) begin
      if (lastLoad > 0 && curSpan > 0) chk("load spacing", cyc - lastLoad, curSpan);
      lastLoad = cyc;
    end
  end

  always @(posedge ref_clk) begin
    if (cyc == 30000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1;
    reg_acc(1, `SDRA_ADDR_CTRL, {30'h0, `SDRA_CTRL_RESET});
    reg_acc(0, 8'h08, 32'hFFFFFFFF);
    reg_acc(0, `SDRA_ADDR_STATUS, 32'h0);
    reg_acc(1, 8'h08, 32'h0);
    reg_acc(1, `SDRA_ADDR_CTRL, {30'h0, `SDRA_CTRL_RESET});
    spanExp = 10 * APER;
    repeat (300) @(posedge ref_clk);
    repeat (12) cpu_acc();
    spanExp = 0;
    reg_acc(0, `SDRA_ADDR_CTRL, 32'h3);
    reg_acc(1, `SDRA_ADDR_CTRL, 32'h3);
    spanExp = 16 * APER;
    repeat (400) @(posedge ref_clk);
    repeat (4) cpu_acc();
    displayActiveInterval <= 0;
    repeat (5200) @(posedge ref_clk);
    chk("refresh rate", refCount >= 20, 1'h1);
    test_done();
  end
endmodule
